// >>> rtl/beep_pkg.sv
// constants shared by the checkpoint beep encoder
package beep_pkg;
   localparam logic [15:0] CHECKPOINT_PORT = 16'h0080;
   localparam int ADDR_WIDTH = 16;
   localparam int CODE_WIDTH = 8;
   localparam int GROUP_WIDTH = 2;
   localparam int GROUP_COUNT = 4;
   localparam int CLOCK_HZ = 50_000_000;
   // beep timing in milliseconds
   localparam int BEEP_MS = 200;
   localparam int GAP_MS = 100;
   localparam int PAUSE_MS = 500;
   localparam int BEEP_CYCLES = BEEP_MS * (CLOCK_HZ / 1000);
   localparam int GAP_CYCLES = GAP_MS * (CLOCK_HZ / 1000);
   localparam int PAUSE_CYCLES = PAUSE_MS * (CLOCK_HZ / 1000);
   localparam logic [7:0] CODE_RESET = 8'h00;
   localparam logic [6:0] SEG_BLANK = 7'h00;
   typedef enum {IDLE, TONE, GAP, PAUSE} beep_state_type;
endpackage

// >>> rtl/hex_digit.sv
// one nibble to seven-segment pattern (gfedcba, active high)
`timescale 1ns/1ps
module hex_digit
(
   input wire logic [3:0] nibble_i,
   output logic [6:0] segments_o
);
   always_comb
   begin
      case (nibble_i)
         4'h0: segments_o = 7'h3f;
         4'h1: segments_o = 7'h06;
         4'h2: segments_o = 7'h5b;
         4'h3: segments_o = 7'h4f;
         4'h4: segments_o = 7'h66;
         4'h5: segments_o = 7'h6d;
         4'h6: segments_o = 7'h7d;
         4'h7: segments_o = 7'h07;
         4'h8: segments_o = 7'h7f;
         4'h9: segments_o = 7'h6f;
         4'ha: segments_o = 7'h77;
         4'hb: segments_o = 7'h7c;
         4'hc: segments_o = 7'h39;
         4'hd: segments_o = 7'h5e;
         4'he: segments_o = 7'h79;
         default: segments_o = 7'h71;
      endcase
   end
endmodule

// >>> rtl/beep_sequencer.sv
// plays four groups of one to four beeps from an 8-bit code
`timescale 1ns/1ps
module beep_sequencer
   import beep_pkg::*;
#(
   parameter int BEEP_LEN = BEEP_CYCLES,
   parameter int GAP_LEN = GAP_CYCLES,
   parameter int PAUSE_LEN = PAUSE_CYCLES
)
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic start_i,
   input wire logic [CODE_WIDTH-1:0] code_i,
   output logic tone_o,
   output logic busy_o
);
   import beep_pkg::*;
   beep_state_type state, next_state;
   logic [31:0] timer, next_timer;
   logic [1:0] group, next_group;
   logic [2:0] left, next_left;
   logic [CODE_WIDTH-1:0] code, next_code;
   logic [2:0] group_beeps;

   // beeps for the current group, msb pair first, one-based
   always_comb
   begin
      group_beeps = {1'b0, code[(3 - group) * GROUP_WIDTH +: GROUP_WIDTH]} + 3'd1;
   end

   always_comb
   begin
      next_state = state;
      next_timer = timer;
      next_group = group;
      next_left = left;
      next_code = code;
      case (state)
         IDLE:
         begin
            if (start_i)
            begin
               next_code = code_i;
               next_group = 2'd0;
               next_left = {1'b0, code_i[7:6]} + 3'd1;
               next_timer = 32'(BEEP_LEN - 1);
               next_state = TONE;
            end
         end
         TONE:
         begin
            if (timer != 32'd0)
               next_timer = timer - 32'd1;
            else if (left > 3'd1)
            begin
               next_left = left - 3'd1;
               next_timer = 32'(GAP_LEN - 1);
               next_state = GAP;
            end
            else if (group == 2'd3)
               next_state = IDLE;
            else
            begin
               next_group = group + 2'd1;
               next_timer = 32'(PAUSE_LEN - 1);
               next_state = PAUSE;
            end
         end
         GAP:
         begin
            if (timer != 32'd0)
               next_timer = timer - 32'd1;
            else
            begin
               next_timer = 32'(BEEP_LEN - 1);
               next_state = TONE;
            end
         end
         PAUSE:
         begin
            if (timer != 32'd0)
               next_timer = timer - 32'd1;
            else
            begin
               next_left = group_beeps;
               next_timer = 32'(BEEP_LEN - 1);
               next_state = TONE;
            end
         end
         default: next_state = IDLE;
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state <= IDLE;
         timer <= 32'd0;
         group <= 2'd0;
         left <= 3'd0;
         code <= CODE_RESET;
      end
      else
      begin
         state <= next_state;
         timer <= next_timer;
         group <= next_group;
         left <= next_left;
         code <= next_code;
      end
   end

   assign tone_o = (state == TONE);
   assign busy_o = (state != IDLE);
endmodule

// >>> rtl/checkpoint_encoder.sv
// checkpoint capture, hex display, lcd output and beep code player
`timescale 1ns/1ps
module checkpoint_encoder
   import beep_pkg::*;
#(
   parameter int BEEP_LEN = BEEP_CYCLES,
   parameter int GAP_LEN = GAP_CYCLES,
   parameter int PAUSE_LEN = PAUSE_CYCLES
)
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic io_write_i,
   input wire logic [ADDR_WIDTH-1:0] io_addr_i,
   input wire logic [CODE_WIDTH-1:0] io_data_i,
   input wire logic [255:0] beep_enable_i,
   output logic [CODE_WIDTH-1:0] checkpoint_code_o,
   output logic [CODE_WIDTH-1:0] lcd_code_o,
   output logic lcd_strobe_o,
   output logic [6:0] led_high_o,
   output logic [6:0] led_low_o,
   output logic speaker_o,
   output logic beep_busy_o
);
   import beep_pkg::*;

   // ***********************************
   // checkpoint capture
   // ***********************************
   logic [CODE_WIDTH-1:0] checkpoint_code, next_checkpoint_code;
   logic lcd_strobe, next_lcd_strobe;
   logic start, next_start;
   logic hit;
   logic [6:0] seg_high, seg_low, led_high, led_low;
   logic tone, busy, speaker, beep_busy;

   assign hit = io_write_i && (io_addr_i == CHECKPOINT_PORT);

   always_comb
   begin
      next_checkpoint_code = checkpoint_code;
      next_lcd_strobe = 1'b0;
      next_start = 1'b0;
      if (hit)
      begin
         next_checkpoint_code = io_data_i;
         next_lcd_strobe = 1'b1;
         next_start = beep_enable_i[io_data_i] && !busy && !start;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         checkpoint_code <= CODE_RESET;
         lcd_strobe <= 1'b0;
         start <= 1'b0;
         led_high <= SEG_BLANK;
         led_low <= SEG_BLANK;
         speaker <= 1'b0;
         beep_busy <= 1'b0;
      end
      else
      begin
         checkpoint_code <= next_checkpoint_code;
         lcd_strobe <= next_lcd_strobe;
         start <= next_start;
         led_high <= seg_high;
         led_low <= seg_low;
         speaker <= tone;
         beep_busy <= busy || start;
      end
   end

   // ***********************************
   // displays and beeper
   // ***********************************
   hex_digit high_digit
   (
      .nibble_i(checkpoint_code[7:4]),
      .segments_o(seg_high)
   );

   hex_digit low_digit
   (
      .nibble_i(checkpoint_code[3:0]),
      .segments_o(seg_low)
   );

   beep_sequencer #(
      .BEEP_LEN(BEEP_LEN),
      .GAP_LEN(GAP_LEN),
      .PAUSE_LEN(PAUSE_LEN)
   ) sequencer
   (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .start_i(start),
      .code_i(checkpoint_code),
      .tone_o(tone),
      .busy_o(busy)
   );

   assign checkpoint_code_o = checkpoint_code;
   assign lcd_code_o = checkpoint_code;
   assign lcd_strobe_o = lcd_strobe;
   assign led_high_o = led_high;
   assign led_low_o = led_low;
   assign speaker_o = speaker;
   assign beep_busy_o = beep_busy;

   // ***********************************
   // assertions
   // ***********************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   capture_write_a: assert property (hit |=> checkpoint_code == $past(io_data_i))
      else $error("checkpoint not captured");
   hold_code_a: assert property (!hit |=> $stable(checkpoint_code))
      else $error("checkpoint changed without write");
   lcd_strobe_a: assert property (hit |=> lcd_strobe)
      else $error("lcd strobe missing");
   digit_low_a: assert property ($changed(checkpoint_code[3:0]) |=> $changed(led_low))
      else $error("low digit did not follow nibble");
   silent_skip_a: assert property (hit && !beep_enable_i[io_data_i] && !busy |=> !start)
      else $error("disabled checkpoint started beeping");
   start_busy_a: assert property (start |=> busy)
      else $error("sequence did not start");
   ignore_busy_a: assert property (busy |-> !next_start)
      else $error("request accepted while busy");
   beep_length_a: assert property ($rose(tone) |-> tone [*2])
      else $error("beep too short");
   speaker_follow_a: assert property (tone |=> speaker)
      else $error("speaker not following tone");
   first_beep_a: assert property (start |=> tone)
      else $error("first beep missing");

   played_c: cover property (start ##1 busy [*3] ##1 tone);
   skipped_c: cover property (hit && !beep_enable_i[io_data_i]);
   busy_write_c: cover property (hit && busy);
endmodule

// >>> verif/host_port_model.sv
// host firmware side: single-cycle checkpoint writes on the I/O port
`timescale 1ns/1ps
module host_port_model
   import beep_pkg::*;
(
   input wire logic clk_i,
   output logic io_write_o,
   output logic [ADDR_WIDTH-1:0] io_addr_o,
   output logic [CODE_WIDTH-1:0] io_data_o
);
   initial
   begin
      io_write_o = 1'b0;
      io_addr_o = 16'hffff;
      io_data_o = 8'hff;
   end
   // one write, launched and released on falling edges
   task automatic write_port(input logic [ADDR_WIDTH-1:0] addr, input logic [CODE_WIDTH-1:0] data);
      @(negedge clk_i);
      io_write_o = 1'b1;
      io_addr_o = addr;
      io_data_o = data;
      @(negedge clk_i);
      io_write_o = 1'b0;
      io_addr_o = ~addr;
      io_data_o = ~data;
   endtask
endmodule

// >>> verif/checkpoint_encoder_test.sv
// self-checking bench for the checkpoint encoder
`timescale 1ns/1ps
module checkpoint_encoder_test;
   import beep_pkg::*;
   localparam int BL = 4;
   localparam int GL = 2;
   localparam int PL = 8;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic io_write;
   logic [15:0] io_addr;
   logic [7:0] io_data;
   logic [255:0] beep_enable = 256'h0;
   logic [7:0] code;
   logic [7:0] lcd;
   logic strobe;
   logic speaker;
   logic busy;
   logic [6:0] led_hi;
   logic [6:0] led_lo;
   int error_cnt = 0;
   int check_count = 0;
   always #10 clk = ~clk;
   host_port_model host (.clk_i(clk), .io_write_o(io_write), .io_addr_o(io_addr), .io_data_o(io_data));
   checkpoint_encoder #(.BEEP_LEN(BL), .GAP_LEN(GL), .PAUSE_LEN(PL)) uut (.clk_i(clk), .rst_n_i(rst_n),
      .io_write_i(io_write), .io_addr_i(io_addr), .io_data_i(io_data), .beep_enable_i(beep_enable),
      .checkpoint_code_o(code), .lcd_code_o(lcd), .lcd_strobe_o(strobe), .led_high_o(led_hi),
      .led_low_o(led_lo), .speaker_o(speaker), .beep_busy_o(busy));
   // ***********************************
   // helpers
   // ***********************************
   task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
      check_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic capture(input logic [15:0] addr, input logic [7:0] data, input logic [7:0] exp);
      host.write_port(addr, data);
      check8(code, exp, "code");
      check8(lcd, exp, "lcd");
      check8({7'h0, strobe}, {7'h0, addr == CHECKPOINT_PORT}, "strobe");
   endtask
   task automatic leds(input logic [6:0] hi, input logic [6:0] lo);
      @(negedge clk);
      check8({1'b0, led_hi}, {1'b0, hi}, "led high");
      check8({1'b0, led_lo}, {1'b0, lo}, "led low");
   endtask
   // measures every tone and silence until the four groups are heard
   task automatic play(input logic [7:0] exp_code);
      int run;
      int g;
      int cnt;
      g = 0;
      cnt = 0;
      for (run = 0; run < 8 && speaker !== 1'b1; run++)
         @(negedge clk);
      for (int k = 0; k < 20 && g < 4; k++)
      begin
         for (run = 0; speaker === 1'b1 && run < 20; run++)
            @(negedge clk);
         check8(8'(run), 8'(BL), "beep length");
         cnt++;
         for (run = 0; speaker !== 1'b1 && busy === 1'b1 && run < 20; run++)
            @(negedge clk);
         if (run == PL || busy !== 1'b1)
         begin
            check8(8'(cnt), {6'h0, exp_code[7 - 2 * g -: 2]} + 8'h01, "group beeps");
            g++;
            cnt = 0;
         end
         else
            check8(8'(run), 8'(GL), "gap length");
      end
      check8(8'(g), 8'h04, "groups heard");
   endtask
   // ***********************************
   // scenarios
   // ***********************************
   task automatic s_beep;
      capture(16'h0080, 8'h4b, 8'h4b);
      leds(7'h66, 7'h7c);
      play(8'h4b);
   endtask
   task automatic s_other;
      capture(16'h0081, 8'h11, 8'h4b);
   endtask
   task automatic s_busy;
      capture(16'h0080, 8'h00, 8'h00);
      fork
         play(8'h00);
         begin
            repeat (4) @(negedge clk);
            capture(16'h0080, 8'hff, 8'hff);
         end
      join
      capture(16'h0080, 8'h00, 8'h00);
      fork
         play(8'h00);
         begin
            repeat (3) @(negedge clk);
            capture(16'h0080, 8'hff, 8'hff);
         end
      join
      repeat (6) @(negedge clk);
      check8({7'h0, busy}, 8'h00, "no restart");
   endtask
   task automatic s_silent;
      capture(16'h0080, 8'h22, 8'h22);
      leds(7'h5b, 7'h5b);
      repeat (4) @(negedge clk);
      check8({6'h0, busy, speaker}, 8'h00, "silent");
   endtask
   initial
   begin
      beep_enable[8'h4b] = 1'b1;
      beep_enable[8'h00] = 1'b1;
      beep_enable[8'hff] = 1'b1;
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      check8(code, 8'h00, "reset code");
      check8({1'b0, led_lo}, 8'h3f, "reset led");
      s_beep;
      s_other;
      s_busy;
      s_silent;
      end_of_test;
   end
   initial
   begin
      #200us;
      error_cnt++;
      end_of_test;
   end
endmodule
